// File: src/mps_top.sv
// Memory map decoder and flash, lock, fuse and signature access policy
`timescale 1ns/10ps
`default_nettype none
module mps_top #(
	parameter bit SMALL_PART = 1'b0
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	input  wire logic        i_prg_valid,
	input  wire logic [2:0]  i_prg_cmd,
	input  wire logic [8:0]  i_prg_idx,
	input  wire logic [7:0]  i_prg_wdata,
	output logic      [7:0]  o_prg_rdata,
	input  wire logic        i_fl_req,
	input  wire logic        i_fl_we,
	input  wire logic        i_fl_from_prg,
	input  wire logic        i_fl_is_ps,
	input  wire logic [16:0] i_fl_pc,
	input  wire logic [16:0] i_fl_addr,
	output logic             o_fl_grant,
	output logic             o_fl_deny,
	output logic             o_flash_erase,
	input  wire logic        i_flash_erase_done,
	output logic             o_erase_busy,
	input  wire logic        i_ds_req,
	input  wire logic        i_ds_we,
	input  wire logic [23:0] i_ds_addr,
	input  wire logic [7:0]  i_ds_wdata,
	output logic      [2:0]  o_ds_rgn,
	output logic             o_ds_done,
	output logic             o_ds_busy,
	output logic      [7:0]  o_ds_rdata,
	output logic             o_ee_pbuf_load,
	input  wire logic        i_io_valid,
	input  wire logic [2:0]  i_io_op,
	input  wire logic [11:0] i_io_addr,
	input  wire logic [2:0]  i_io_bit,
	output logic             o_io_ok,
	output logic             o_io_skip,
	output logic             o_cal_valid,
	output logic      [3:0]  o_cal_idx,
	output logic      [7:0]  o_cal_data
);
	mps_sig_if sig ();

	mps_sig_rows u_rows (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.sig       (sig.rows)
	);

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	// Section of a flash word address
	function automatic mps_pkg::mps_sec_t sect(input logic [16:0] a);
		logic [16:0] tl;
		logic [16:0] bl;
		logic [16:0] en;
		tl = SMALL_PART ? mps_pkg::FL_TBL_SM : mps_pkg::FL_TBL_LG;
		bl = SMALL_PART ? mps_pkg::FL_BOOT_SM : mps_pkg::FL_BOOT_LG;
		en = SMALL_PART ? mps_pkg::FL_END_SM : mps_pkg::FL_END_LG;
		if (a < tl) sect = mps_pkg::SEC_APP;
		else if (a < bl) sect = mps_pkg::SEC_TBL;
		else if (a <= en) sect = mps_pkg::SEC_BOOT;
		else sect = mps_pkg::SEC_NONE;
	endfunction : sect

	// Lock bit pair per section: bit 0 write, bit 1 read; one means open
	function automatic logic lk_open(input logic [5:0] lk, input mps_pkg::mps_sec_t s,
		input logic rd);
		if (s == mps_pkg::SEC_NONE) lk_open = 1'b0;
		else lk_open = lk[{s, rd}];
	endfunction : lk_open

	function automatic mps_pkg::mps_rgn_t region(input logic [23:0] a, input logic map);
		logic [23:0] se;
		se = SMALL_PART ? mps_pkg::DS_SRAM_SM : mps_pkg::DS_SRAM_LG;
		if (a <= mps_pkg::DS_IO_END) region = mps_pkg::RG_IO;
		else if (a <= mps_pkg::DS_EE_END) region = map ? mps_pkg::RG_EE : mps_pkg::RG_RSV;
		else if (a < mps_pkg::DS_SRAM_LO) region = mps_pkg::RG_RSV;
		else if (a <= se) region = mps_pkg::RG_SRAM;
		else region = mps_pkg::RG_EXT;
	endfunction : region

	// Register and protection state
	logic [7:0] ctrl_q, ctrl_d;
	logic [5:0] lock_q, lock_d;
	logic [7:0] fuse_q, fuse_d;
	logic       psrej_q, psrej_d;
	logic [3:0] psidx_q, psidx_d;
	logic [8:0] usidx_q, usidx_d;
	logic [7:0] rrd_q, rrd_d;
	logic [7:0] prd_q, prd_d;
	mps_pkg::mps_er_t  er_q, er_d;
	mps_pkg::mps_cal_t cal_q, cal_d;
	logic [3:0] calix_q, calix_d;
	logic       calv_q, calv_d;
	logic [7:0] cald_q, cald_d;
	logic       sw_wr, prg_cmd;
	logic       ps_bad, busy;
	mps_pkg::mps_sec_t fsec, psec;
	mps_pkg::mps_pcmd_t pcmd;

	assign pcmd    = mps_pkg::mps_pcmd_t'(i_prg_cmd);
	assign sw_wr   = i_reg_wr;
	assign prg_cmd = i_prg_valid;
	assign fsec    = sect(i_fl_addr);
	assign psec    = sect(i_fl_pc);
	assign busy    = (er_q != mps_pkg::ER_IDLE);

	// Flash access policy
	always_comb begin
		logic wr_ok;
		logic rd_ok;
		wr_ok = 1'b0;
		rd_ok = 1'b0;
		wr_ok = (i_fl_from_prg || (i_fl_is_ps && psec == mps_pkg::SEC_BOOT))
			&& lk_open(lock_q, fsec, 1'b0);
		rd_ok = lk_open(lock_q, fsec, 1'b1) || (!i_fl_from_prg && psec == fsec);
		o_fl_grant = i_fl_req && !busy && fsec != mps_pkg::SEC_NONE
			&& (i_fl_we ? wr_ok : rd_ok);
		o_fl_deny = i_fl_req && !o_fl_grant;
	end
	assign ps_bad = i_fl_req && i_fl_is_ps && !i_fl_from_prg && psec != mps_pkg::SEC_BOOT;

	// Signature row ports: a is software and calibration, b is programmer
	always_comb begin
		sig.psig_ridx_a  = (cal_q != mps_pkg::CAL_DONE) ? calix_q : psidx_q;
		sig.psig_ridx_b  = i_prg_idx[3:0];
		sig.usig_ridx_a  = usidx_q;
		sig.usig_ridx_b  = i_prg_idx;
		sig.usig_we_a    = sw_wr && i_reg_addr == mps_pkg::R_USDAT;
		sig.usig_widx_a  = usidx_q;
		sig.usig_wdata_a = i_reg_wdata;
		sig.usig_we_b    = prg_cmd && pcmd == mps_pkg::PC_WR_USIG;
		sig.usig_widx_b  = i_prg_idx;
		sig.usig_wdata_b = i_prg_wdata;
		sig.usig_erase   = prg_cmd && pcmd == mps_pkg::PC_USIG_ERASE;
	end

	always_comb begin
		ctrl_d  = ctrl_q;
		lock_d  = lock_q;
		fuse_d  = fuse_q;
		psidx_d = psidx_q;
		usidx_d = usidx_q;
		rrd_d   = 8'h00;
		prd_d   = 8'h00;
		psrej_d = psrej_q;
		if (sw_wr) begin
			case (i_reg_addr)
				mps_pkg::R_CTRL:  ctrl_d = i_reg_wdata;
				mps_pkg::R_LOCK:  lock_d = lock_d & i_reg_wdata[5:0];
				mps_pkg::R_STAT:  psrej_d = psrej_q & ~i_reg_wdata[mps_pkg::ST_PSREJ];
				mps_pkg::R_PSIDX: psidx_d = i_reg_wdata[3:0];
				mps_pkg::R_USIDX: usidx_d = {1'b0, i_reg_wdata};
				default: ;
			endcase
		end
		if (ps_bad) psrej_d = 1'b1;
		if (prg_cmd && pcmd == mps_pkg::PC_WR_FUSE) fuse_d = i_prg_wdata;
		if (prg_cmd && pcmd == mps_pkg::PC_WR_LOCK) begin
			lock_d = lock_d & i_prg_wdata[5:0];
		end
		if (er_q == mps_pkg::ER_LOCKS) lock_d = mps_pkg::LOCK_RST;
		if (i_reg_rd) begin
			case (i_reg_addr)
				mps_pkg::R_CTRL:  rrd_d = ctrl_q;
				mps_pkg::R_LOCK:  rrd_d = {2'b11, lock_q};
				mps_pkg::R_FUSE:  rrd_d = fuse_q;
				mps_pkg::R_STAT:  rrd_d = {5'h00, cal_q == mps_pkg::CAL_DONE, busy, psrej_q};
				mps_pkg::R_PSIDX: rrd_d = {4'h0, psidx_q};
				mps_pkg::R_PSDAT: rrd_d = sig.psig_rdata_a;
				mps_pkg::R_USIDX: rrd_d = usidx_q[7:0];
				mps_pkg::R_USDAT: rrd_d = sig.usig_rdata_a;
				default: rrd_d = 8'h00;
			endcase
		end
		if (prg_cmd) begin
			case (pcmd)
				mps_pkg::PC_RD_PSIG: prd_d = sig.psig_rdata_b;
				mps_pkg::PC_RD_USIG: prd_d = sig.usig_rdata_b;
				mps_pkg::PC_RD_FUSE: prd_d = fuse_q;
				default: prd_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_q  <= 8'h00;
			lock_q  <= mps_pkg::LOCK_RST;
			fuse_q  <= mps_pkg::FUSE_RST;
			psidx_q <= 4'h0;
			usidx_q <= 9'h000;
			rrd_q   <= 8'h00;
			prd_q   <= 8'h00;
			psrej_q <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			lock_q  <= lock_d;
			fuse_q  <= fuse_d;
			psidx_q <= psidx_d;
			usidx_q <= usidx_d;
			rrd_q   <= rrd_d;
			prd_q   <= prd_d;
			psrej_q <= psrej_d;
		end
	end
	assign o_reg_rdata = rrd_q;
	assign o_prg_rdata = prd_q;

	// Chip erase: flash first, locks last
	always_comb begin
		er_d = er_q;
		case (er_q)
			mps_pkg::ER_IDLE: if (prg_cmd && pcmd == mps_pkg::PC_CHIP_ERASE) begin
				er_d = mps_pkg::ER_FLASH;
			end
			mps_pkg::ER_FLASH: if (i_flash_erase_done) er_d = mps_pkg::ER_LOCKS;
			mps_pkg::ER_LOCKS: er_d = mps_pkg::ER_IDLE;
			default: er_d = mps_pkg::ER_IDLE;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) er_q <= mps_pkg::ER_IDLE;
		else er_q <= er_d;
	end
	assign o_flash_erase = (er_q == mps_pkg::ER_FLASH);
	assign o_erase_busy  = busy;

	// Calibration copy after reset release
	always_comb begin
		cal_d   = cal_q;
		calix_d = calix_q;
		calv_d  = 1'b0;
		cald_d  = cald_q;
		case (cal_q)
			mps_pkg::CAL_RUN: begin
				calv_d  = 1'b1;
				cald_d  = sig.psig_rdata_a;
				calix_d = calix_q + 4'h1;
				if (calix_q == mps_pkg::CAL_LAST) cal_d = mps_pkg::CAL_LAST_ST;
			end
			mps_pkg::CAL_LAST_ST: cal_d = mps_pkg::CAL_DONE;
			mps_pkg::CAL_DONE: ;
			default: cal_d = mps_pkg::CAL_DONE;
		endcase
	end
	logic [3:0] calo_q;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cal_q   <= mps_pkg::CAL_RUN;
			calix_q <= mps_pkg::CAL_BASE;
			calv_q  <= 1'b0;
			cald_q  <= 8'h00;
			calo_q  <= 4'h0;
		end else begin
			cal_q   <= cal_d;
			calix_q <= calix_d;
			calv_q  <= calv_d;
			cald_q  <= cald_d;
			calo_q  <= calix_q;
		end
	end
	assign o_cal_valid = calv_q;
	assign o_cal_idx   = calo_q;
	assign o_cal_data  = cald_q;

	// Data space timing, general purpose registers and I/O instructions
	mps_pkg::mps_rgn_t rg;
	logic [7:0] gpr_q [16];
	logic [7:0] gpr_d [16];
	logic done1_q, done1_d, rd1_q, rd1_d, rd2_q, rd2_d;
	logic pbuf_q, pbuf_d, skip_q, skip_d;
	logic [7:0] dsr_q, dsr_d;
	logic gpr_hit, io_gpr;

	assign rg       = region(i_ds_addr, ctrl_q[mps_pkg::CTRL_EEMAP]);
	assign o_ds_rgn = rg;
	assign gpr_hit  = rg == mps_pkg::RG_IO && i_ds_addr[11:0] <= mps_pkg::IO_GPR_END;
	assign io_gpr   = i_io_addr <= mps_pkg::IO_GPR_END;

	always_comb begin
		case (mps_pkg::mps_ioop_t'(i_io_op))
			mps_pkg::OP_IN, mps_pkg::OP_OUT: o_io_ok = i_io_addr <= mps_pkg::IO_DIR_END;
			mps_pkg::OP_SETB, mps_pkg::OP_CLRB, mps_pkg::OP_SKS, mps_pkg::OP_SKC:
				o_io_ok = i_io_addr <= mps_pkg::IO_BIT_END;
			default: o_io_ok = 1'b0;
		endcase
	end

	always_comb begin
		logic bv;
		bv = gpr_q[i_io_addr[3:0]][i_io_bit];
		gpr_d   = gpr_q;
		done1_d = i_ds_req && !(rg == mps_pkg::RG_SRAM && !i_ds_we);
		rd1_d   = i_ds_req && rg == mps_pkg::RG_SRAM && !i_ds_we;
		rd2_d   = rd1_q;
		pbuf_d  = i_ds_req && i_ds_we && rg == mps_pkg::RG_EE;
		dsr_d   = 8'h00;
		skip_d  = 1'b0;
		if (i_ds_req && gpr_hit) begin
			if (i_ds_we) gpr_d[i_ds_addr[3:0]] = i_ds_wdata;
			else dsr_d = gpr_q[i_ds_addr[3:0]];
		end
		if (i_io_valid && o_io_ok && io_gpr) begin
			case (mps_pkg::mps_ioop_t'(i_io_op))
				mps_pkg::OP_SETB: gpr_d[i_io_addr[3:0]][i_io_bit] = 1'b1;
				mps_pkg::OP_CLRB: gpr_d[i_io_addr[3:0]][i_io_bit] = 1'b0;
				mps_pkg::OP_SKS:  skip_d = bv;
				mps_pkg::OP_SKC:  skip_d = !bv;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < 16; i++) begin
				gpr_q[i] <= 8'h00;
			end
			done1_q <= 1'b0;
			rd1_q   <= 1'b0;
			rd2_q   <= 1'b0;
			pbuf_q  <= 1'b0;
			dsr_q   <= 8'h00;
			skip_q  <= 1'b0;
		end else begin
			gpr_q   <= gpr_d;
			done1_q <= done1_d;
			rd1_q   <= rd1_d;
			rd2_q   <= rd2_d;
			pbuf_q  <= pbuf_d;
			dsr_q   <= dsr_d;
			skip_q  <= skip_d;
		end
	end
	assign o_ds_done      = done1_q || rd2_q;
	assign o_ds_busy      = rd1_q;
	assign o_ds_rdata     = dsr_q;
	assign o_ee_pbuf_load = pbuf_q;
	assign o_io_skip      = skip_q;

	property p_ps_nonboot;
		ps_bad |-> !o_fl_grant;
	endproperty
	a_ps_nonboot: assert property (p_ps_nonboot) else $error("store from outside boot");
	property p_ps_boot;
		i_fl_req && i_fl_we && i_fl_is_ps && psec == mps_pkg::SEC_BOOT && !busy
			&& lk_open(lock_q, fsec, 1'b0) |-> o_fl_grant;
	endproperty
	a_ps_boot: assert property (p_ps_boot) else $error("boot store refused");
	property p_lock_tight;
		er_q != mps_pkg::ER_LOCKS |=> (lock_q & ~$past(lock_q)) == 6'h00;
	endproperty
	a_lock_tight: assert property (p_lock_tight) else $error("lock loosened");
	property p_lock_clr;
		er_q == mps_pkg::ER_FLASH && i_flash_erase_done |=> ##1
			lock_q == mps_pkg::LOCK_RST && !busy;
	endproperty
	a_lock_clr: assert property (p_lock_clr) else $error("locks not cleared last");
	property p_fuse_sw;
		!(prg_cmd && pcmd == mps_pkg::PC_WR_FUSE) |=> $stable(fuse_q);
	endproperty
	a_fuse_sw: assert property (p_fuse_sw) else $error("fuse changed without programmer");
	property p_usig_keep;
		o_flash_erase && !(prg_cmd && pcmd == mps_pkg::PC_USIG_ERASE) |-> !sig.usig_erase;
	endproperty
	a_usig_keep: assert property (p_usig_keep) else $error("user row erased");
	property p_sram_rd;
		i_ds_req && !i_ds_we && rg == mps_pkg::RG_SRAM |=> !o_ds_done ##1 o_ds_done;
	endproperty
	a_sram_rd: assert property (p_sram_rd) else $error("sram read timing");
	property p_rsv;
		i_ds_req && rg == mps_pkg::RG_RSV |=> o_ds_done && o_ds_rdata == 8'h00
			&& !o_ee_pbuf_load;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved gap access");
	property p_io_dir;
		(i_io_op == mps_pkg::OP_IN || i_io_op == mps_pkg::OP_OUT)
			&& i_io_addr > mps_pkg::IO_DIR_END |-> !o_io_ok;
	endproperty
	a_io_dir: assert property (p_io_dir) else $error("direct io out of range");
	property p_ee_map;
		i_ds_req && i_ds_we && rg == mps_pkg::RG_EE |=> o_ee_pbuf_load && o_ds_done;
	endproperty
	a_ee_map: assert property (p_ee_map) else $error("eeprom store lost");
endmodule : mps_top
`default_nettype wire

// File: src/mps_pkg.sv
// Constants and types for the memory map and section protection block
package mps_pkg;
	localparam int FA_W = 17;
	localparam int DA_W = 24;
	localparam int FW_W = 16;
	localparam logic [16:0] FL_TBL_LG  = 17'h0f000;
	localparam logic [16:0] FL_BOOT_LG = 17'h10000;
	localparam logic [16:0] FL_END_LG  = 17'h10fff;
	localparam logic [16:0] FL_TBL_SM  = 17'h07800;
	localparam logic [16:0] FL_BOOT_SM = 17'h08000;
	localparam logic [16:0] FL_END_SM  = 17'h087ff;
	localparam logic [23:0] DS_IO_END   = 24'h000fff;
	localparam logic [23:0] DS_EE_END   = 24'h0017ff;
	localparam logic [23:0] DS_SRAM_LO  = 24'h002000;
	localparam logic [23:0] DS_SRAM_LG  = 24'h003fff;
	localparam logic [23:0] DS_SRAM_SM  = 24'h002fff;
	localparam logic [11:0] IO_DIR_END  = 12'h03f;
	localparam logic [11:0] IO_BIT_END  = 12'h01f;
	localparam logic [11:0] IO_GPR_END  = 12'h00f;
	localparam logic [7:0] R_CTRL   = 8'h00;
	localparam logic [7:0] R_LOCK   = 8'h04;
	localparam logic [7:0] R_FUSE   = 8'h08;
	localparam logic [7:0] R_STAT   = 8'h0c;
	localparam logic [7:0] R_PSIDX  = 8'h10;
	localparam logic [7:0] R_PSDAT  = 8'h14;
	localparam logic [7:0] R_USIDX  = 8'h18;
	localparam logic [7:0] R_USDAT  = 8'h1c;
	localparam int CTRL_EEMAP = 0;
	localparam int ST_PSREJ   = 0;
	localparam int ST_BUSY    = 1;
	localparam int ST_CALDONE = 2;
	localparam logic [5:0] LOCK_RST = 6'h3f;
	localparam logic [7:0] FUSE_RST = 8'hff;
	localparam logic [7:0] ERASED   = 8'hff;
	localparam int PSIG_N = 16;
	localparam int USIG_N = 512;
	localparam logic [3:0] CAL_BASE = 4'h9;
	localparam logic [3:0] CAL_LAST = 4'hc;
	typedef enum logic [1:0] {SEC_APP = 2'h0, SEC_TBL = 2'h1, SEC_BOOT = 2'h2,
		SEC_NONE = 2'h3} mps_sec_t;
	typedef enum logic [2:0] {RG_IO = 3'h0, RG_EE = 3'h1, RG_RSV = 3'h2,
		RG_SRAM = 3'h3, RG_EXT = 3'h4} mps_rgn_t;
	typedef enum logic [2:0] {OP_IN = 3'h0, OP_OUT = 3'h1, OP_SETB = 3'h2,
		OP_CLRB = 3'h3, OP_SKS = 3'h4, OP_SKC = 3'h5} mps_ioop_t;
	typedef enum logic [2:0] {PC_WR_FUSE = 3'h0, PC_WR_LOCK = 3'h1, PC_CHIP_ERASE = 3'h2,
		PC_USIG_ERASE = 3'h3, PC_WR_USIG = 3'h4, PC_RD_PSIG = 3'h5, PC_RD_USIG = 3'h6,
		PC_RD_FUSE = 3'h7} mps_pcmd_t;
	typedef enum logic [2:0] {ER_IDLE = 3'b001, ER_FLASH = 3'b010,
		ER_LOCKS = 3'b100} mps_er_t;
	typedef enum logic [2:0] {CAL_RUN = 3'b001, CAL_LAST_ST = 3'b010,
		CAL_DONE = 3'b100} mps_cal_t;
endpackage : mps_pkg

// File: src/mps_sig_if.sv
// Signature row access signals between the policy logic and the row storage
`timescale 1ns/10ps
`default_nettype none
interface mps_sig_if;
	logic [3:0] psig_ridx_a;
	logic [3:0] psig_ridx_b;
	logic [7:0] psig_rdata_a;
	logic [7:0] psig_rdata_b;
	logic [8:0] usig_ridx_a;
	logic [8:0] usig_ridx_b;
	logic [7:0] usig_rdata_a;
	logic [7:0] usig_rdata_b;
	logic       usig_we_a;
	logic       usig_we_b;
	logic [8:0] usig_widx_a;
	logic [8:0] usig_widx_b;
	logic [7:0] usig_wdata_a;
	logic [7:0] usig_wdata_b;
	logic       usig_erase;
	modport ctl (output psig_ridx_a, psig_ridx_b, usig_ridx_a, usig_ridx_b, usig_we_a,
		usig_we_b, usig_widx_a, usig_widx_b, usig_wdata_a, usig_wdata_b, usig_erase,
		input psig_rdata_a, psig_rdata_b, usig_rdata_a, usig_rdata_b);
	modport rows (input psig_ridx_a, psig_ridx_b, usig_ridx_a, usig_ridx_b, usig_we_a,
		usig_we_b, usig_widx_a, usig_widx_b, usig_wdata_a, usig_wdata_b, usig_erase,
		output psig_rdata_a, psig_rdata_b, usig_rdata_a, usig_rdata_b);
endinterface : mps_sig_if
`default_nettype wire

// File: src/mps_sig_rows.sv
// Production signature row (fixed) and user signature row (one page)
`timescale 1ns/10ps
`default_nettype none
module mps_sig_rows #(
	parameter logic [7:0] ID0   = 8'h5a, // Arbitrary value
	parameter logic [7:0] ID1   = 8'h3c, // Arbitrary value
	parameter logic [7:0] ID2   = 8'h01, // Arbitrary value
	parameter logic [23:0] LOT  = 24'h000001,
	parameter logic [7:0] WAFER = 8'h01,
	parameter logic [15:0] XY   = 16'h0000,
	parameter logic [31:0] CAL  = 32'h80808080
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	mps_sig_if.rows   sig
);
	logic [7:0] usig_q [mps_pkg::USIG_N];
	logic [7:0] usig_d [mps_pkg::USIG_N];

	// Fixed content, no write path exists
	function automatic logic [7:0] psig_byte(input logic [3:0] idx);
		case (idx)
			4'h0: psig_byte = ID0;
			4'h1: psig_byte = ID1;
			4'h2: psig_byte = ID2;
			4'h3: psig_byte = LOT[7:0];
			4'h4: psig_byte = LOT[15:8];
			4'h5: psig_byte = LOT[23:16];
			4'h6: psig_byte = WAFER;
			4'h7: psig_byte = XY[7:0];
			4'h8: psig_byte = XY[15:8];
			4'h9: psig_byte = CAL[7:0];
			4'ha: psig_byte = CAL[15:8];
			4'hb: psig_byte = CAL[23:16];
			4'hc: psig_byte = CAL[31:24];
			default: psig_byte = mps_pkg::ERASED;
		endcase
	endfunction : psig_byte

	assign sig.psig_rdata_a = psig_byte(sig.psig_ridx_a);
	assign sig.psig_rdata_b = psig_byte(sig.psig_ridx_b);
	assign sig.usig_rdata_a = usig_q[sig.usig_ridx_a];
	assign sig.usig_rdata_b = usig_q[sig.usig_ridx_b];

	always_comb begin
		usig_d = usig_q;
		if (sig.usig_erase) begin
			for (int i = 0; i < mps_pkg::USIG_N; i++) begin
				usig_d[i] = mps_pkg::ERASED;
			end
		end else begin
			if (sig.usig_we_a) begin
				usig_d[sig.usig_widx_a] = sig.usig_wdata_a;
			end
			if (sig.usig_we_b) begin
				usig_d[sig.usig_widx_b] = sig.usig_wdata_b;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < mps_pkg::USIG_N; i++) begin
				usig_q[i] <= mps_pkg::ERASED;
			end
		end else begin
			usig_q <= usig_d;
		end
	end
endmodule : mps_sig_rows
`default_nettype wire

// File: dv/mps_flash_model.sv
// Flash array stand-in: ends a requested array erase after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module mps_flash_model #(
	parameter int ERASE_CYC = 10
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_erase,
	output logic      o_done
);
	int cnt;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			o_done <= 1'b0;
		end else begin
			o_done <= i_erase && !o_done && cnt == ERASE_CYC;
			cnt <= (i_erase && !o_done) ? cnt + 1 : 0;
		end
	end
endmodule : mps_flash_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the memory map and section protection block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        i_clk_sys = 1'b0, i_resetn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic        i_prg_valid = 1'b0, i_fl_req = 1'b0, i_fl_we = 1'b0, i_fl_from_prg = 1'b0;
	logic        i_fl_is_ps = 1'b0, i_ds_req = 1'b0, i_ds_we = 1'b0, i_io_valid = 1'b0;
	logic [7:0]  i_reg_addr = '0, i_reg_wdata = '0, i_prg_wdata = '0, i_ds_wdata = '0;
	logic [2:0]  i_prg_cmd = '0, i_io_op = '0, i_io_bit = '0;
	logic [8:0]  i_prg_idx = '0;
	logic [16:0] i_fl_pc = '0, i_fl_addr = '0;
	logic [23:0] i_ds_addr = '0;
	logic [11:0] i_io_addr = '0;
	logic [7:0]  o_reg_rdata, o_prg_rdata, o_ds_rdata, o_cal_data;
	logic [3:0]  o_cal_idx;
	logic [2:0]  o_ds_rgn;
	logic        o_fl_grant, o_fl_deny, o_flash_erase, i_flash_erase_done, o_erase_busy;
	logic        o_ds_done, o_ds_busy, o_ee_pbuf_load, o_io_ok, o_io_skip, o_cal_valid;
	logic        rd_d = 1'b0, pg_d = 1'b0;
	logic        sm_grant;
	logic [2:0]  sm_rgn;
	logic [7:0]  rq[$], pq[$];
	logic [7:0]  id[3] = '{8'h5a, 8'h3c, 8'h01};
	logic [23:0] da[8] = '{24'h000fff, 24'h001000, 24'h0017ff, 24'h001800, 24'h002000,
		24'h003fff, 24'h004000, 24'hffffff};
	logic [2:0]  dr[8] = '{3'h0, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
	int          err_total = 0, checks_done = 0, cyc = 0, cal_n = 0, i, n;

	always #25 i_clk_sys = ~i_clk_sys;

	mps_top DUT (.i_clk_sys, .i_resetn, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_reg_rdata, .i_prg_valid, .i_prg_cmd, .i_prg_idx, .i_prg_wdata, .o_prg_rdata,
		.i_fl_req, .i_fl_we, .i_fl_from_prg, .i_fl_is_ps, .i_fl_pc, .i_fl_addr, .o_fl_grant,
		.o_fl_deny, .o_flash_erase, .i_flash_erase_done, .o_erase_busy, .i_ds_req, .i_ds_we,
		.i_ds_addr, .i_ds_wdata, .o_ds_rgn, .o_ds_done, .o_ds_busy, .o_ds_rdata,
		.o_ee_pbuf_load, .i_io_valid, .i_io_op, .i_io_addr, .i_io_bit, .o_io_ok, .o_io_skip,
		.o_cal_valid, .o_cal_idx, .o_cal_data);
	mps_flash_model FLM (.i_clk_sys, .i_resetn, .i_erase(o_flash_erase),
		.o_done(i_flash_erase_done));
	// Small part variant: only section and region decode are watched
	mps_top #(.SMALL_PART(1'b1)) DUT_SM (.i_clk_sys, .i_resetn, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .i_reg_rd, .o_reg_rdata(), .i_prg_valid, .i_prg_cmd, .i_prg_idx,
		.i_prg_wdata, .o_prg_rdata(), .i_fl_req, .i_fl_we, .i_fl_from_prg, .i_fl_is_ps,
		.i_fl_pc, .i_fl_addr, .o_fl_grant(sm_grant), .o_fl_deny(), .o_flash_erase(),
		.i_flash_erase_done, .o_erase_busy(), .i_ds_req, .i_ds_we, .i_ds_addr, .i_ds_wdata,
		.o_ds_rgn(sm_rgn), .o_ds_done(), .o_ds_busy(), .o_ds_rdata(), .o_ee_pbuf_load(),
		.i_io_valid, .i_io_op, .i_io_addr, .i_io_bit, .o_io_ok(), .o_io_skip(),
		.o_cal_valid(), .o_cal_idx(), .o_cal_data());

	task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
	endtask : rd

	task automatic pg(input logic [2:0] c, input logic [8:0] x, input logic [7:0] d, e);
		if (c >= 3'h5) pq.push_back(e);
		@(posedge i_clk_sys);
		i_prg_valid <= 1'b1;
		i_prg_cmd <= c;
		i_prg_idx <= x;
		i_prg_wdata <= d;
		@(posedge i_clk_sys);
		i_prg_valid <= 1'b0;
	endtask : pg

	task automatic fl(input logic w, p, s, input logic [16:0] pc, a, input logic g);
		@(posedge i_clk_sys);
		{i_fl_req, i_fl_we, i_fl_from_prg, i_fl_is_ps} <= {1'b1, w, p, s};
		{i_fl_pc, i_fl_addr} <= {pc, a};
		@(negedge i_clk_sys);
		cmp("fl_grant", g, o_fl_grant);
		cmp("fl_deny", !g, o_fl_deny);
		@(posedge i_clk_sys);
		i_fl_req <= 1'b0;
	endtask : fl

	task automatic dsx(input logic w, input logic [23:0] a, input logic [7:0] d,
			input int lat, input logic [7:0] e, input logic pb);
		@(posedge i_clk_sys);
		{i_ds_req, i_ds_we, i_ds_addr, i_ds_wdata} <= {1'b1, w, a, d};
		@(posedge i_clk_sys);
		i_ds_req <= 1'b0;
		n = 1;
		@(negedge i_clk_sys);
		cmp("ds_busy", 24'(lat == 2), 24'(o_ds_busy));
		while (o_ds_done !== 1'b1 && n < 5) begin
			@(negedge i_clk_sys);
			n++;
		end
		cmp("ds_lat", 24'(lat), 24'(n));
		cmp("ds_rdata", e, o_ds_rdata);
		cmp("ee_pbuf", pb, o_ee_pbuf_load);
	endtask : dsx

	task automatic iox(input logic [2:0] op, input logic [11:0] a, input logic ok, sk);
		@(posedge i_clk_sys);
		{i_io_valid, i_io_op, i_io_addr, i_io_bit} <= {1'b1, op, a, 3'h3};
		@(negedge i_clk_sys);
		cmp("io_ok", ok, o_io_ok);
		@(posedge i_clk_sys);
		i_io_valid <= 1'b0;
		@(negedge i_clk_sys);
		cmp("io_skip", sk, o_io_skip);
	endtask : iox

	// Result watcher: read data stand only in the cycle after the strobe
	always @(posedge i_clk_sys) begin
		rd_d <= i_reg_rd;
		pg_d <= i_prg_valid && i_prg_cmd >= 3'h5;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			final_report();
		end
	end
	always @(negedge i_clk_sys) begin
		if (rd_d) cmp("reg_rdata", rq.pop_front(), o_reg_rdata);
		if (pg_d) cmp("prg_rdata", pq.pop_front(), o_prg_rdata);
		if (o_cal_valid === 1'b1) begin
			cmp("cal_idx", 24'(cal_n + 9), o_cal_idx);
			cmp("cal_data", 8'h80, o_cal_data);
			cal_n++;
		end
	end

	initial begin
		n = $urandom(32'h43e81020);
		repeat (4) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
		cmp("cal_count", 24'h4, 24'(cal_n));
		rd(mps_pkg::R_LOCK, 8'hff);
		rd(mps_pkg::R_FUSE, 8'hff);
		rd(8'h20, 8'h00);
		for (i = 0; i < 3; i++) pg(3'h5, 9'(i), 8'h00, id[i]);
		pg(3'h5, 9'h006, 8'h00, 8'h01);
		wr(mps_pkg::R_PSIDX, 8'h00);
		wr(mps_pkg::R_PSDAT, 8'h00);
		rd(mps_pkg::R_PSDAT, 8'h5a);
		pg(3'h0, 9'h000, 8'h7f, 8'h00);
		wr(mps_pkg::R_FUSE, 8'h00);
		rd(mps_pkg::R_FUSE, 8'h7f);
		pg(3'h7, 9'h000, 8'h00, 8'h7f);
		fl(1, 0, 1, 17'h00000, 17'h00010, 0);
		fl(1, 0, 1, 17'h0f000, 17'h00010, 0);
		fl(1, 0, 0, 17'h10000, 17'h00010, 0);
		fl(1, 0, 1, 17'h10fff, 17'h10000, 1);
		fl(1, 0, 1, 17'h10000, 17'h11000, 0);
		fl(1, 1, 0, 17'h00000, 17'h0ffff, 1);
		fl(0, 0, 0, 17'h00000, 17'h0efff, 1);
		for (i = 0; i < 8; i++) fl(1, 0, 1, 17'h10800, 17'($urandom_range(17'h0efff)), 1);
		@(posedge i_clk_sys);
		{i_fl_req, i_fl_we, i_fl_is_ps, i_fl_pc, i_fl_addr} <= {3'b111, 17'h08000, 17'h00010};
		@(negedge i_clk_sys);
		cmp("fl_grant_sm", 24'h1, 24'(sm_grant));
		cmp("fl_grant", 24'h0, 24'(o_fl_grant));
		@(posedge i_clk_sys);
		i_fl_req <= 1'b0;
		rd(mps_pkg::R_STAT, 8'h05);
		wr(mps_pkg::R_STAT, 8'h01);
		wr(mps_pkg::R_LOCK, 8'h3e);
		wr(mps_pkg::R_LOCK, 8'hff);
		rd(mps_pkg::R_LOCK, 8'hfe);
		fl(1, 0, 1, 17'h10000, 17'h00100, 0);
		fl(1, 0, 1, 17'h10000, 17'h0f000, 1);
		pg(3'h1, 9'h000, 8'h3d, 8'h00);
		rd(mps_pkg::R_LOCK, 8'hfc);
		fl(0, 1, 0, 17'h00000, 17'h00100, 0);
		wr(mps_pkg::R_USIDX, 8'h05);
		wr(mps_pkg::R_USDAT, 8'ha5);
		pg(3'h6, 9'h005, 8'h00, 8'ha5);
		pg(3'h2, 9'h000, 8'h00, 8'h00);
		rd(mps_pkg::R_LOCK, 8'hfc);
		rd(mps_pkg::R_STAT, 8'h06);
		@(negedge i_clk_sys);
		cmp("flash_erase", 24'h1, 24'(o_flash_erase));
		cmp("erase_busy", 24'h1, 24'(o_erase_busy));
		for (n = 0; n < 40 && o_erase_busy !== 1'b0; n++) @(negedge i_clk_sys);
		rd(mps_pkg::R_LOCK, 8'hff);
		@(negedge i_clk_sys);
		cmp("flash_erase", 24'h0, 24'(o_flash_erase));
		cmp("erase_busy", 24'h0, 24'(o_erase_busy));
		pg(3'h6, 9'h005, 8'h00, 8'ha5);
		pg(3'h3, 9'h000, 8'h00, 8'h00);
		pg(3'h6, 9'h005, 8'h00, 8'hff);
		rd(mps_pkg::R_USDAT, 8'hff);
		for (i = 0; i < 8; i++) begin
			@(posedge i_clk_sys);
			i_ds_addr <= da[i];
			@(negedge i_clk_sys);
			cmp("ds_rgn", dr[i], o_ds_rgn);
			cmp("ds_rgn_sm", (da[i] == 24'h003fff) ? 3'h4 : dr[i], sm_rgn);
		end
		wr(mps_pkg::R_CTRL, 8'h01);
		dsx(1, 24'h0017ff, 8'h11, 1, 8'h00, 1);
		cmp("ds_rgn", 3'h1, o_ds_rgn);
		dsx(0, 24'h002000, 8'h00, 2, 8'h00, 0);
		dsx(1, 24'h002001, 8'h05, 1, 8'h00, 0);
		dsx(1, 24'h001900, 8'h77, 1, 8'h00, 0);
		dsx(0, 24'h001900, 8'h00, 1, 8'h00, 0);
		iox(mps_pkg::OP_SETB, 12'h002, 1, 0);
		iox(mps_pkg::OP_SKS, 12'h002, 1, 1);
		iox(mps_pkg::OP_SKC, 12'h002, 1, 0);
		iox(mps_pkg::OP_IN, 12'h03f, 1, 0);
		iox(mps_pkg::OP_OUT, 12'h040, 0, 0);
		iox(mps_pkg::OP_CLRB, 12'h020, 0, 0);
		dsx(0, 24'h000002, 8'h00, 1, 8'h08, 0);
		repeat (4) @(posedge i_clk_sys);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
